// File: verilog/tmon_pkg.sv
// Shared constants and types for the temperature monitor and channel control link
package tmon_pkg;
   localparam int CHAN_W = 5;
   localparam int RES_W = 12;
   localparam int MODE_W = 2;
   localparam int QUADS = 10;
   localparam int SEL_W = 8;
   localparam int KELV_W = 12;
   localparam logic [CHAN_W-1:0] CH_CORE_SUPPLY = 5'h00;
   localparam logic [CHAN_W-1:0] CH_INT_TEMP = 5'h1f;
   localparam int CH_PER_QUAD = 3;
   localparam logic [CHAN_W-1:0] CH_LAST_QUAD = 5'h1e;
   localparam logic [CHAN_W-1:0] CH_OFF_VOLT = 5'h01;
   localparam logic [CHAN_W-1:0] CH_OFF_CURR = 5'h02;
   localparam logic [CHAN_W-1:0] CH_OFF_TEMP = 5'h03;
   localparam logic [MODE_W-1:0] MODE_10B = 2'h0;
   localparam logic [MODE_W-1:0] MODE_12B = 2'h1;
   localparam logic [MODE_W-1:0] MODE_8B = 2'h2;
   localparam logic [MODE_W-1:0] MODE_BAD = 2'h3;
   localparam int SHIFT_8B = 4;
   localparam int SHIFT_10B = 2;
   localparam int SHIFT_8B_K = 2;
   localparam int THROUGHPUT_KSPS = 500;
   localparam int SAMPLE_CYC = 4;
   localparam int DIST_8B = 8;
   localparam int DIST_10B = 10;
   localparam int DIST_12B = 12;
   localparam int CNT_W = 8;
   localparam logic [KELV_W-1:0] OFFSET_K = 12'h005;
   typedef enum logic [1:0] {CH_SUPPLY, CH_VOLT, CH_CURR, CH_TEMP} chan_kind_e;
endpackage : tmon_pkg

// File: verilog/tmon_link_if.sv
// Link between the user control logic and the analog converter block
`timescale 1ns/1ps
`default_nettype none
interface tmon_link_if
   import tmon_pkg::*;
   (
   input wire logic mclk,
   input wire logic rst_b
   );
   logic convStart;
   logic [CHAN_W-1:0] channelSelect;
   logic [MODE_W-1:0] resMode;
   logic [QUADS-1:0] tempStrobe;
   logic internalTempStrobe;
   logic busy;
   logic sample;
   logic dataValid;
   logic [RES_W-1:0] result;
   logic [RES_W-1:0] analogCode;
   modport conv (input mclk, rst_b, convStart, channelSelect, resMode, tempStrobe, internalTempStrobe,
      analogCode, output busy, sample, dataValid, result);
   modport ctrl (input mclk, rst_b, busy, sample, dataValid, result, output convStart, channelSelect,
      resMode, tempStrobe, internalTempStrobe);
endinterface : tmon_link_if
`default_nettype wire

// File: verilog/tmon_adc_end.sv
// Converter end: channel multiplexer decode, conversion sequencing, MSB-justified result
`timescale 1ns/1ps
`default_nettype none
// Operation
// R1 - Control drives quad temperature strobe high
// R2 - Strobe held high until sampling ends
// R3 - Sample time covers strobe high minus setup
// R4 - Ten-bit temperature code equals kelvin
// R5 - Eight-bit temperature code is four kelvin
// R6 - Twelve-bit temperature still one kelvin resolution
// R7 - Consumer may subtract five degree offset
// R8 - Eight, ten, twelve bits, MSB-justified results
// R9 - Twelve-bit throughput up to 500 ksps
// R10 - Channel 31 internal diode, 0 supply
// R11 - Internal diode strobed before channel 31
// R12 - Five-bit channel number selects input
// R13 - Quad q uses channels 3q+1..3q+3
// R14 - Thirty user channels, population varies
// R15 - Channel number is plain unsigned binary
// R16 - Mode 00=10b, 01=12b, 10=8b
// R17 - Conversion start sampled on rising edge
// R18 - Sample high in sample phase, busy kept
// R19 - Channel and strobe stable during sampling
// R20 - Capture after valid, then scale kelvin
module tmon_adc_end
   (
   tmon_link_if.conv link,
   output logic [tmon_pkg::CHAN_W-1:0] capturedChannel,
   output logic capturedStrobed
   );
   import tmon_pkg::*;

   // ----------------------------------------------------------
   // Channel decode
   // ----------------------------------------------------------
   typedef enum {IDLE, SAMPLING, DISTRIB} phase_e;
   phase_e phase_r;
   phase_e phase_nxt;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic [CHAN_W-1:0] chan_r;
   logic [MODE_W-1:0] mode_r;
   logic strobed_r;
   logic [RES_W-1:0] code_r;
   logic valid_r;
   logic startSeen;
   logic isTempChan;
   logic chanStrobe;
   logic [CNT_W-1:0] distLen;
   logic [RES_W-1:0] justified;
   logic [CHAN_W-1:0] quadIdx;
   logic quadPresent;
   logic padStrobe;
   logic strobeNow;
   logic [MODE_W-1:0] modeSafe;
   logic inIdle;
   logic inSample;
   logic inDist;
   logic sampleDone;
   logic distDone;
   logic [RES_W-1:0] just8;
   logic [RES_W-1:0] just10;

   // Phase flags and the last cycle of each timed phase
   assign inIdle = (phase_r == IDLE);
   assign inSample = (phase_r == SAMPLING); // R18
   assign inDist = (phase_r == DISTRIB);
   assign sampleDone = inSample && (cnt_r == '0); // R3 R18
   assign distDone = inDist && (cnt_r == '0);

   // Temperature channels are offsets 3 within each quad, plus the internal diode
   function automatic logic isTemp(input logic [CHAN_W-1:0] ch);
      isTemp = (ch == CH_INT_TEMP) ||
         ((ch != CH_CORE_SUPPLY) && (ch <= CH_LAST_QUAD) && ((ch % CH_PER_QUAD) == 0)); // R13 R10
   endfunction : isTemp

   assign isTempChan = isTemp(link.channelSelect); // R12 R15
   assign quadIdx = CHAN_W'((link.channelSelect - CH_OFF_VOLT) / CH_PER_QUAD); // R13
   assign quadPresent = (quadIdx < QUADS); // R14
   assign padStrobe = quadPresent ? link.tempStrobe[quadIdx[3:0]] : 1'b0; // R1 R14
   assign chanStrobe = (link.channelSelect == CH_INT_TEMP) ? link.internalTempStrobe : padStrobe; // R10 R11
   assign startSeen = link.convStart && inIdle; // R17

   // Strobe qualification and resolution code taken at start
   assign strobeNow = isTempChan ? chanStrobe : 1'b1; // R1 R11
   assign modeSafe = (link.resMode == MODE_BAD) ? MODE_10B : link.resMode; // R16

   // Distribution cycles follow the latched resolution
   assign distLen = (mode_r == MODE_8B) ? CNT_W'(DIST_8B) :
      (mode_r == MODE_12B) ? CNT_W'(DIST_12B) :
      CNT_W'(DIST_10B); // R8 R16

   // Code with the bits below each resolution forced to zero
   assign just8 = {link.analogCode[RES_W-1:SHIFT_8B], {SHIFT_8B{1'b0}}}; // R5 R8
   assign just10 = {link.analogCode[RES_W-1:SHIFT_10B], {SHIFT_10B{1'b0}}}; // R4 R8

   // Result justified to the top of the bus for the latched width
   assign justified = (mode_r == MODE_8B) ? just8 :
      (mode_r == MODE_10B) ? just10 :
      link.analogCode; // R6 R8

   // ----------------------------------------------------------
   // Conversion sequencing
   // ----------------------------------------------------------
   always_comb
   begin
      phase_nxt = phase_r;
      cnt_nxt = cnt_r;
      unique case (phase_r)
         IDLE:
         begin
            if (startSeen)
            begin
               phase_nxt = SAMPLING;
               cnt_nxt = CNT_W'(SAMPLE_CYC - 1); // R3 R9
            end
         end
         SAMPLING:
         begin
            if (cnt_r == '0)
            begin
               phase_nxt = DISTRIB;
               cnt_nxt = distLen - 1'b1;
            end
            else
               cnt_nxt = cnt_r - 1'b1;
         end
         DISTRIB:
         begin
            if (cnt_r == '0)
               phase_nxt = IDLE;
            else
               cnt_nxt = cnt_r - 1'b1;
         end
      endcase
   end

   // Phase state and counter
   always_ff @(posedge link.mclk or negedge link.rst_b)
   begin
      if (!link.rst_b)
      begin
         phase_r <= IDLE;
         cnt_r <= '0;
      end
      else
      begin
         phase_r <= phase_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Channel and resolution latched when a start is accepted
   always_ff @(posedge link.mclk or negedge link.rst_b)
   begin
      if (!link.rst_b)
      begin
         chan_r <= '0;
         mode_r <= MODE_10B;
      end
      else if (startSeen)
      begin
         chan_r <= link.channelSelect; // R12
         mode_r <= modeSafe; // R16
      end
   end

   // Strobe seen at start and kept high through the whole sample phase
   always_ff @(posedge link.mclk or negedge link.rst_b)
   begin
      if (!link.rst_b)
         strobed_r <= 1'b0;
      else if (startSeen)
         strobed_r <= strobeNow; // R1 R11
      else if (inSample)
         strobed_r <= strobed_r & strobeNow; // R2 R19
   end

   // Analog code taken on the last sample cycle
   always_ff @(posedge link.mclk or negedge link.rst_b)
   begin
      if (!link.rst_b)
         code_r <= '0;
      else if (sampleDone)
         code_r <= justified; // R4 R5 R6
   end

   // Valid rises as busy falls and holds until the next start
   always_ff @(posedge link.mclk or negedge link.rst_b)
   begin
      if (!link.rst_b)
         valid_r <= 1'b0;
      else if (startSeen)
         valid_r <= 1'b0;
      else if (distDone)
         valid_r <= 1'b1;
   end

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------
   // Phase flags and the latched result onto the link
   assign link.busy = !inIdle; // R18
   assign link.sample = inSample; // R18
   assign link.dataValid = valid_r;
   assign link.result = code_r; // R8

   // Latched channel and strobe record for the side outputs
   assign capturedChannel = chan_r;
   assign capturedStrobed = strobed_r;
endmodule : tmon_adc_end
`default_nettype wire

// File: verilog/tmon_ctrl_end.sv
// Control end: strobes monitors, selects channels, scales results to kelvin
`timescale 1ns/1ps
`default_nettype none
module tmon_ctrl_end
   (
   tmon_link_if.ctrl link,
   input wire logic req,
   input wire logic [tmon_pkg::CHAN_W-1:0] reqChannel,
   input wire logic [tmon_pkg::MODE_W-1:0] reqMode,
   input wire logic subtractOffset,
   output logic reqReady,
   output logic done,
   output logic [tmon_pkg::RES_W-1:0] rawResult,
   output logic [tmon_pkg::KELV_W-1:0] kelvin
   );
   import tmon_pkg::*;

   // ----------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------
   typedef enum {IDLE, STROBE, START, WAITS, WAITV} step_e;
   step_e step_r;
   step_e step_nxt;
   logic [CHAN_W-1:0] chan_r;
   logic [MODE_W-1:0] mode_r;
   logic strobe_r;
   logic start_r;
   logic done_r;
   logic [RES_W-1:0] raw_r;
   logic [KELV_W-1:0] kelvin_r;
   logic [KELV_W-1:0] scaled;
   logic [KELV_W-1:0] corrected;
   logic tempReq;
   logic [CHAN_W-1:0] quadIdx;
   logic accept;

   assign tempReq = (chan_r == CH_INT_TEMP) || ((chan_r != CH_CORE_SUPPLY) && (chan_r <= CH_LAST_QUAD)
      && ((chan_r % CH_PER_QUAD) == 0));
   assign quadIdx = CHAN_W'((chan_r - CH_OFF_VOLT) / CH_PER_QUAD);
   assign reqReady = (step_r == IDLE);
   assign accept = req && (reqMode != MODE_BAD); // R16

   always_comb
   begin
      step_nxt = step_r;
      unique case (step_r)
         IDLE: if (accept) step_nxt = STROBE; // R16
         STROBE: step_nxt = START;
         START: step_nxt = WAITS;
         WAITS: if (!link.sample && !link.convStart && link.busy) step_nxt = WAITV; // R2
         WAITV: if (link.dataValid) step_nxt = IDLE; // R20
      endcase
   end

   // Scaling from the justified result to kelvin
   assign scaled = (mode_r == MODE_8B) ? KELV_W'({raw_r[RES_W-1:SHIFT_8B], {SHIFT_8B_K{1'b0}}}) : // R5
      (mode_r == MODE_12B) ? KELV_W'(raw_r[RES_W-1:SHIFT_10B]) : // R6
      KELV_W'(raw_r[RES_W-1:SHIFT_10B]); // R4
   assign corrected = subtractOffset ? scaled - OFFSET_K : scaled; // R7

   // Held request fields; sampling tempReq uses chan_r after capture
   always_ff @(posedge link.mclk or negedge link.rst_b)
   begin
      if (!link.rst_b)
      begin
         step_r <= IDLE;
         chan_r <= '0;
         mode_r <= MODE_10B;
      end
      else
      begin
         step_r <= step_nxt;
         if (step_r == IDLE && accept)
         begin
            chan_r <= reqChannel; // R12 R15 R19
            mode_r <= reqMode; // R16
         end
      end
   end

   // Strobe, start and result capture
   always_ff @(posedge link.mclk or negedge link.rst_b)
   begin
      if (!link.rst_b)
      begin
         strobe_r <= 1'b0;
         start_r <= 1'b0;
         done_r <= 1'b0;
         raw_r <= '0;
         kelvin_r <= '0;
      end
      else
      begin
         if (step_r == STROBE)
            strobe_r <= tempReq; // R1 R3 R11
         else if (step_r == WAITV || step_r == IDLE)
            strobe_r <= 1'b0; // R2
         start_r <= (step_r == START); // R17
         done_r <= (step_r == WAITV) && link.dataValid;
         if (step_r == WAITV && link.dataValid)
            raw_r <= link.result; // R20
         if (done_r)
            kelvin_r <= corrected;
      end
   end

   // ----------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------
   assign link.convStart = start_r;
   assign link.channelSelect = chan_r;
   assign link.resMode = mode_r;
   assign link.internalTempStrobe = strobe_r && (chan_r == CH_INT_TEMP);
   assign link.tempStrobe = (strobe_r && chan_r != CH_INT_TEMP) ? (QUADS'(1) << quadIdx) : '0;
   assign done = done_r;
   assign rawResult = raw_r;
   assign kelvin = kelvin_r;
endmodule : tmon_ctrl_end
`default_nettype wire

// File: bench/tmon_link_checker.sv
// Concurrent checks on the link between the control end and the converter end
`timescale 1ns/1ps
`default_nettype none
module tmon_link_checker
   import tmon_pkg::*;
   (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic convStart,
   input wire logic [CHAN_W-1:0] channelSelect,
   input wire logic [MODE_W-1:0] resMode,
   input wire logic [QUADS-1:0] tempStrobe,
   input wire logic internalTempStrobe,
   input wire logic busy,
   input wire logic sample,
   input wire logic dataValid,
   input wire logic [RES_W-1:0] result
   );
   // Temperature pad channel decode and its quad index
   wire padTemp = (channelSelect % 5'h03 == 5'h00) && channelSelect != CH_CORE_SUPPLY && channelSelect != CH_INT_TEMP;
   wire [CHAN_W-1:0] quadIdx = channelSelect / 5'h03 - 5'h01;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_start_sample: assert property (convStart && !busy |=> sample && busy)
      else $error("Sample phase did not follow an idle start");
   chk_sample_len: assert property ($rose(sample) |-> sample [*4] ##1 !sample)
      else $error("Sample phase length wrong");
   chk_sample_busy: assert property (sample |-> busy)
      else $error("Busy low during sample phase");
   chk_dist_8b: assert property ($fell(sample) && resMode == MODE_8B |-> busy [*8] ##1 !busy)
      else $error("Eight bit distribution length wrong");
   chk_dist_10b: assert property ($fell(sample) && resMode == MODE_10B |-> busy [*8] ##1 busy [*2] ##1 !busy)
      else $error("Ten bit distribution length wrong");
   chk_dist_12b: assert property ($fell(sample) && resMode == MODE_12B |-> busy [*8] ##1 busy [*4] ##1 !busy)
      else $error("Twelve bit distribution length wrong");
   chk_valid_rise: assert property ($fell(busy) |-> dataValid)
      else $error("Data valid missing as busy falls");
   chk_valid_hold: assert property (dataValid && !convStart |=> dataValid)
      else $error("Data valid dropped without a start");
   chk_just_8b: assert property ($rose(dataValid) && resMode == MODE_8B |-> result[3:0] == 4'h0)
      else $error("Eight bit result not MSB justified");
   chk_just_10b: assert property ($rose(dataValid) && resMode == MODE_10B |-> result[1:0] == 2'h0)
      else $error("Ten bit result not MSB justified");
   chk_int_strobe: assert property (sample && channelSelect == CH_INT_TEMP |-> internalTempStrobe)
      else $error("Internal diode not strobed while sampled");
   chk_pad_strobe: assert property (sample && padTemp |-> tempStrobe[quadIdx])
      else $error("Quad strobe low while its pad is sampled");
   chk_chan_stable: assert property (busy |-> $stable(channelSelect))
      else $error("Channel changed during conversion");
   chk_mode_legal: assert property (resMode != MODE_BAD)
      else $error("Unused resolution code driven");
   chk_strobe_setup: assert property (convStart && !busy && padTemp |-> tempStrobe[quadIdx])
      else $error("Quad strobe low at conversion start");
   chk_int_setup: assert property (convStart && !busy && channelSelect == CH_INT_TEMP |-> internalTempStrobe)
      else $error("Internal diode strobe low at conversion start");
   chk_strobe_steady: assert property (sample |-> $stable(tempStrobe) && $stable(internalTempStrobe))
      else $error("Strobe changed during sample phase");
endmodule : tmon_link_checker
`default_nettype wire

// File: bench/temp_monitor_adc_channel_control_tb.sv
// Testbench joining the control end and the converter end over the link
`timescale 1ns/1ps
`default_nettype none
module temp_monitor_adc_channel_control_tb;
   import tmon_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic req = 1'b0;
   logic [CHAN_W-1:0] reqChannel = 5'h00;
   logic [MODE_W-1:0] reqMode = 2'h0;
   logic subtractOffset = 1'b0;
   logic reqReady;
   logic done;
   logic [RES_W-1:0] rawResult;
   logic [KELV_W-1:0] kelvin;
   logic [CHAN_W-1:0] capturedChannel;
   logic capturedStrobed;
   int fails = 0;
   int num_checks = 0;
   logic [CHAN_W-1:0] chs [6] = '{5'h03, 5'h1f, 5'h00, 5'h1e, 5'h15, 5'h01};
   logic [MODE_W-1:0] modes [6] = '{MODE_10B, MODE_12B, MODE_8B, MODE_10B, MODE_10B, MODE_8B};
   logic [RES_W-1:0] codes [6] = '{12'h4a8, 12'h4ab, 12'h4ac, 12'h4a8, 12'h3a7, 12'hfff};
   logic offs [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
   // ----------------------------------------
   // Structure
   // ----------------------------------------
   tmon_link_if link (.mclk(mclk), .rst_b(rst_b));
   tmon_adc_end u_tmon_adc_end (.link(link.conv), .capturedChannel(capturedChannel),
      .capturedStrobed(capturedStrobed));
   tmon_ctrl_end u_tmon_ctrl_end (.link(link.ctrl), .req(req), .reqChannel(reqChannel), .reqMode(reqMode),
      .subtractOffset(subtractOffset), .reqReady(reqReady), .done(done), .rawResult(rawResult),
      .kelvin(kelvin));
   tmon_link_checker u_tmon_link_checker (.mclk(mclk), .rst_b(rst_b), .convStart(link.convStart),
      .channelSelect(link.channelSelect), .resMode(link.resMode), .tempStrobe(link.tempStrobe),
      .internalTempStrobe(link.internalTempStrobe), .busy(link.busy), .sample(link.sample),
      .dataValid(link.dataValid), .result(link.result));
   // Clock at 100 ns period
   always #50 mclk = ~mclk;
   // Compare and count
   task check(input logic [KELV_W-1:0] got, input logic [KELV_W-1:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Print the counts and the verdict, then stop
   task close_out;
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : close_out
   // One request through the control end, expected values from the resolution rules
   task convert(input logic [CHAN_W-1:0] ch, input logic [MODE_W-1:0] mode, input logic [RES_W-1:0] code,
      input logic off);
      int n;
      logic [RES_W-1:0] raw;
      logic [KELV_W-1:0] k;
      raw = (mode == MODE_8B) ? {code[11:4], 4'h0} : (mode == MODE_12B) ? code : {code[11:2], 2'h0};
      k = (mode == MODE_8B) ? {2'h0, code[11:4], 2'h0} : {2'h0, code[11:2]};
      k = off ? k - OFFSET_K : k;
      @(posedge mclk);
      reqChannel <= ch;
      reqMode <= mode;
      subtractOffset <= off;
      link.analogCode <= code;
      req <= 1'b1;
      @(posedge mclk);
      req <= 1'b0;
      n = 0;
      do
      begin
         @(posedge mclk);
         #1;
         n++;
      end
      while (done !== 1'b1 && n < 200);
      check(done, 1'b1);
      check(rawResult, raw);
      @(posedge mclk);
      #1;
      check(kelvin, k);
      check(capturedChannel, ch);
      check(capturedStrobed, 1'b1);
   endtask : convert
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      link.analogCode <= 12'h000;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 0; i < 6; i++)
         convert(chs[i], modes[i], codes[i], offs[i]);
      @(posedge mclk);
      reqMode <= MODE_BAD;
      req <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      check(reqReady, 1'b1);
      check(link.busy, 1'b0);
      @(posedge mclk);
      req <= 1'b0;
      convert(5'h06, MODE_12B, 12'h4a8, 1'b0);
      close_out();
   end
   // Watchdog against a hang
   initial
   begin
      #2000000;
      fails++;
      close_out();
   end
endmodule : temp_monitor_adc_channel_control_tb
`default_nettype wire
